// ---- design/gsl_map.svh ----
`ifndef GSL_MAP_SVH
`define GSL_MAP_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define GSL_OFF_DIR_SET    12'h518
`define GSL_OFF_DIR_CLR    12'h51c
`define GSL_OFF_HIT        12'h520
`define GSL_OFF_DETSEL     12'h524
`define GSL_OFF_OUT        12'h504
`define GSL_OFF_IN         12'h510
`define GSL_OFF_IRQ_STAT   12'h540
`define GSL_OFF_IRQ_MASK   12'h544
`define GSL_OFF_CFG_BASE   12'h700
`define GSL_OFF_CFG_LAST   12'h77c

// ----------------------------------------
// Configuration field positions
// ----------------------------------------
`define GSL_CFG_DIR_BIT    0
`define GSL_CFG_INBUF_BIT  1
`define GSL_CFG_PULL_LO    2
`define GSL_CFG_PULL_HI    3
`define GSL_CFG_DRIVE_LO   8
`define GSL_CFG_DRIVE_HI   10
`define GSL_CFG_SENSE_LO   16
`define GSL_CFG_SENSE_HI   17

// ----------------------------------------
// Reset values
// ----------------------------------------
`define GSL_CFG_RESET      32'h0000_0002
`define GSL_HIT_RESET      32'h0000_0000
`define GSL_DETSEL_RESET   1'h0
`define GSL_MASK_RESET     2'h0

`endif

// ---- design/gsl_pkg.sv ----
package gsl_pkg;

  // Sense field codes
  typedef enum logic [1:0] {
    GSL_SENSE_OFF  = 2'h0,
    GSL_SENSE_RSV  = 2'h1,
    GSL_SENSE_HIGH = 2'h2,
    GSL_SENSE_LOW  = 2'h3
  } gsl_sense_t;

  // Pull field codes
  typedef enum logic [1:0] {
    GSL_PULL_NONE = 2'h0,
    GSL_PULL_DOWN = 2'h1,
    GSL_PULL_RSV  = 2'h2,
    GSL_PULL_UP   = 2'h3
  } gsl_pull_t;

  typedef logic [31:0] gsl_word_t;
  typedef logic [11:0] gsl_addr_t;

endpackage

// ---- design/gsl_port.sv ----
// Chosen here: the address-and-strobe port.
`timescale 1ns/10ps
`include "gsl_map.svh"
// What this block does
// - Latch bit of a pin sets when its level meets its configured sense criterion.
// - Writing one clears a latch bit; writing zero leaves it.
// - Latch bit reads one after a hit, zero until hit since clear.
// - Thirty-two independent latch bits, pin n at bit n.
// - Detect source select: zero gives raw detect, one gives latched detect.
// - One configuration register per pin from 0x700 upward in order.
// - Sense field: zero off, two high level, three low level.
// - Direction bit: zero input, one output; shared with port direction.
// - Input buffer bit: zero connects, one disconnects, disconnected shows no level.
module gsl_port
(
  // Clock, reset, enable
  input  wire logic              clock,
  input  wire logic              rst_n,
  input  wire logic              clk_en,
  // Register port
  input  wire gsl_pkg::gsl_addr_t addr,
  input  wire gsl_pkg::gsl_word_t wdata,
  input  wire logic              wr_stb,
  input  wire logic              rd_stb,
  output gsl_pkg::gsl_word_t      rdata,
  // Pins
  input  wire logic [31:0]       pin_in,
  output logic [31:0]            pin_out,
  output logic [31:0]            pin_oe,
  output logic [31:0]            pull_up_en,
  output logic [31:0]            pull_down_en,
  // Detect and interrupt
  output logic                   port_detect,
  output logic                   irq
);
  import gsl_pkg::*;

  // ----------------------------------------
  // Decode helpers
  // ----------------------------------------
  // Pin index of a configuration address, or no hit
  function automatic logic cfg_hit(input gsl_addr_t a);
    cfg_hit = (a >= `GSL_OFF_CFG_BASE) && (a <= `GSL_OFF_CFG_LAST) && (a[1:0] == 2'h0);
  endfunction

  function automatic logic [4:0] cfg_idx(input gsl_addr_t a);
    cfg_idx = a[6:2];
  endfunction

  // Does a level meet a sense code
  function automatic logic sense_met(input logic [1:0] s, input logic lvl);
    sense_met = ((s == GSL_SENSE_HIGH) && lvl) || ((s == GSL_SENSE_LOW) && !lvl);
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [31:0] dir_reg,   dir_next;
  logic [31:0] inbuf_reg, inbuf_next;
  logic [1:0]  pull_reg  [32];
  logic [1:0]  pull_next [32];
  logic [2:0]  drive_reg [32];
  logic [2:0]  drive_next[32];
  logic [1:0]  sense_reg [32];
  logic [1:0]  sense_next[32];
  logic [31:0] out_reg,   out_next;
  logic [31:0] hit_reg,   hit_next;
  logic        detsel_reg, detsel_next;
  logic [1:0]  stat_reg,  stat_next;
  logic [1:0]  mask_reg,  mask_next;
  logic        det_prev_reg, det_prev_next;
  gsl_word_t   rdata_reg, rdata_next;
  logic [31:0] sync1_reg, sync2_reg, sync3_reg;
  logic [31:0] lvl_reg,   lvl_next;

  // ----------------------------------------
  // Pin input synchroniser
  // ----------------------------------------
  // Three stages; a level counts once stages two and three agree
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      sync1_reg <= 32'h0;
      sync2_reg <= 32'h0;
      sync3_reg <= 32'h0;
      lvl_reg   <= 32'h0;
    end
    else if (clk_en)
    begin
      sync1_reg <= pin_in;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      lvl_reg   <= lvl_next;
    end
  end

  // Filtered level, gated by the input buffer
  logic [31:0] pin_level;
  always_comb
  begin
    for (int i = 0; i < 32; i++)
    begin
      lvl_next[i] = (sync2_reg[i] == sync3_reg[i]) ? sync3_reg[i] : lvl_reg[i];
    end
  end
  assign pin_level = lvl_reg & ~inbuf_reg;

  // ----------------------------------------
  // Per-pin detect and outputs
  // ----------------------------------------
  logic [31:0] pin_det;
  genvar g;
  generate
    for (g = 0; g < 32; g++)
    begin : g_pin
      // Disconnected buffer never senses
      assign pin_det[g]      = !inbuf_reg[g] && sense_met(sense_reg[g], pin_level[g]);
      assign pull_up_en[g]   = (pull_reg[g] == GSL_PULL_UP);
      assign pull_down_en[g] = (pull_reg[g] == GSL_PULL_DOWN);
    end
  endgenerate

  assign pin_out = out_reg;
  assign pin_oe  = dir_reg;

  // Raw or latched detect
  assign port_detect = detsel_reg ? (|hit_reg) : (|pin_det);
  assign irq         = |(stat_reg & mask_reg);
  assign rdata       = rdata_reg;

  // ----------------------------------------
  // Register next state
  // ----------------------------------------
  always_comb
  begin
    logic [4:0] ix;
    logic       wr_cfg;
    logic       det_rise;
    ix            = cfg_idx(addr);
    wr_cfg        = wr_stb && cfg_hit(addr);
    dir_next      = dir_reg;
    inbuf_next    = inbuf_reg;
    out_next      = out_reg;
    detsel_next   = detsel_reg;
    mask_next     = mask_reg;
    pull_next     = pull_reg;
    drive_next    = drive_reg;
    sense_next    = sense_reg;
    det_prev_next = port_detect;
    rdata_next    = 32'h0;
    det_rise      = port_detect && !det_prev_reg;

    // Write decode
    if (wr_cfg)
    begin
      dir_next[ix]   = wdata[`GSL_CFG_DIR_BIT];
      inbuf_next[ix] = wdata[`GSL_CFG_INBUF_BIT];
      pull_next[ix]  = wdata[`GSL_CFG_PULL_HI:`GSL_CFG_PULL_LO];
      drive_next[ix] = wdata[`GSL_CFG_DRIVE_HI:`GSL_CFG_DRIVE_LO];
      sense_next[ix] = wdata[`GSL_CFG_SENSE_HI:`GSL_CFG_SENSE_LO];
    end
    else if (wr_stb)
    begin
      unique case (addr)
        `GSL_OFF_DIR_SET:  dir_next    = dir_reg | wdata;
        `GSL_OFF_DIR_CLR:  dir_next    = dir_reg & ~wdata;
        `GSL_OFF_OUT:      out_next    = wdata;
        `GSL_OFF_DETSEL:   detsel_next = wdata[0];
        `GSL_OFF_IRQ_MASK: mask_next   = wdata[1:0];
        default:           ;
      endcase
    end

    // Sticky latch: a hit beats a clear in the same cycle
    hit_next = hit_reg & ~((wr_stb && addr == `GSL_OFF_HIT) ? wdata : 32'h0);
    hit_next = hit_next | pin_det;

    // Event status: bit 0 new latch hit, bit 1 detect rising
    stat_next = stat_reg;
    if (rd_stb && addr == `GSL_OFF_IRQ_STAT)
      stat_next = 2'h0;
    stat_next = stat_next | {det_rise, |(pin_det & ~hit_reg)};

    // Read decode
    if (rd_stb)
    begin
      if (cfg_hit(addr))
      begin
        rdata_next[`GSL_CFG_DIR_BIT]                     = dir_reg[ix];
        rdata_next[`GSL_CFG_INBUF_BIT]                   = inbuf_reg[ix];
        rdata_next[`GSL_CFG_PULL_HI:`GSL_CFG_PULL_LO]    = pull_reg[ix];
        rdata_next[`GSL_CFG_DRIVE_HI:`GSL_CFG_DRIVE_LO]  = drive_reg[ix];
        rdata_next[`GSL_CFG_SENSE_HI:`GSL_CFG_SENSE_LO]  = sense_reg[ix];
      end
      else
      begin
        unique case (addr)
          `GSL_OFF_DIR_SET,
          `GSL_OFF_DIR_CLR:  rdata_next = dir_reg;
          `GSL_OFF_OUT:      rdata_next = out_reg;
          `GSL_OFF_IN:       rdata_next = pin_level;
          `GSL_OFF_HIT:      rdata_next = hit_reg;
          `GSL_OFF_DETSEL:   rdata_next = {31'h0, detsel_reg};
          `GSL_OFF_IRQ_STAT: rdata_next = {30'h0, stat_reg};
          `GSL_OFF_IRQ_MASK: rdata_next = {30'h0, mask_reg};
          default:           rdata_next = 32'h0;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Register update
  // ----------------------------------------
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      dir_reg      <= 32'h0;
      inbuf_reg    <= 32'hffff_ffff;
      out_reg      <= 32'h0;
      hit_reg      <= `GSL_HIT_RESET;
      detsel_reg   <= `GSL_DETSEL_RESET;
      stat_reg     <= 2'h0;
      mask_reg     <= `GSL_MASK_RESET;
      det_prev_reg <= 1'h0;
      rdata_reg    <= 32'h0;
      for (int i = 0; i < 32; i++)
      begin
        pull_reg[i]  <= 2'h0;
        drive_reg[i] <= 3'h0;
        sense_reg[i] <= 2'h0;
      end
    end
    else if (clk_en)
    begin
      dir_reg      <= dir_next;
      inbuf_reg    <= inbuf_next;
      out_reg      <= out_next;
      hit_reg      <= hit_next;
      detsel_reg   <= detsel_next;
      stat_reg     <= stat_next;
      mask_reg     <= mask_next;
      det_prev_reg <= det_prev_next;
      rdata_reg    <= rdata_next;
      pull_reg     <= pull_next;
      drive_reg    <= drive_next;
      sense_reg    <= sense_next;
    end
  end

  // ----------------------------------------
  // Latch checks
  // ----------------------------------------
  // Every live hit is latched on the next edge
  a_hit_sets_latch: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && pin_det != 32'h0 |=> (hit_reg & $past(pin_det)) == $past(pin_det))
    else $error("latch bit missed a sense hit");

  // Zero bits of a clear write keep their latch
  a_zero_write_keeps: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && wr_stb && addr == `GSL_OFF_HIT
      |=> ($past(hit_reg) & ~$past(wdata) & ~hit_reg) == 32'h0)
    else $error("zero write cleared a latch bit");

  // One bits clear unless a hit arrives with them
  a_one_write_clears: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && wr_stb && addr == `GSL_OFF_HIT
      |=> (hit_reg & $past(wdata) & ~$past(pin_det)) == 32'h0)
    else $error("one write did not clear latch bit");

  // Latch read returns the word of the read cycle
  a_latch_read_value: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && rd_stb && addr == `GSL_OFF_HIT |=> rdata == $past(hit_reg))
    else $error("latch read mismatch");

  // No latch bit sets without a hit of its own pin
  a_latch_no_spurious: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en |=> (hit_reg & ~$past(hit_reg) & ~$past(pin_det)) == 32'h0)
    else $error("latch bit set without a hit");

  // ----------------------------------------
  // Mode and configuration checks
  // ----------------------------------------
  // Latched mode keeps detect up while a latch bit holds
  a_detect_source: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && detsel_reg && hit_reg != 32'h0 && !wr_stb |=> port_detect)
    else $error("detect source wrong");

  // Configuration write lands in the addressed pin
  a_cfg_dir_write: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && wr_stb && cfg_hit(addr)
      |=> ((dir_reg >> $past(addr[6:2])) & 32'h1) == {31'h0, $past(wdata[0])})
    else $error("pin config write lost");

  // Disabled sense never detects
  a_sense_off_quiet: assert property (@(posedge clock) disable iff (!rst_n)
    sense_reg[2] == GSL_SENSE_OFF |-> !pin_det[2])
    else $error("disabled sense detected");

  // Port-wide direction clear reaches the pin drivers
  a_dir_drives_oe: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && wr_stb && addr == `GSL_OFF_DIR_CLR |=> (pin_oe & $past(wdata)) == 32'h0)
    else $error("output enable not from direction");

  // Disconnected buffer shows no level
  a_inbuf_blocks: assert property (@(posedge clock) disable iff (!rst_n)
    inbuf_reg[1] |-> !pin_level[1] && !pin_det[1])
    else $error("disconnected buffer shows level");

  // Reserved pull code enables neither pull
  a_pull_unsupported: assert property (@(posedge clock) disable iff (!rst_n)
    pull_reg[9] == GSL_PULL_RSV |-> !pull_up_en[9] && !pull_down_en[9])
    else $error("reserved pull code drives a pull");

  // Pull-up code enables only the pull-up
  a_pull_up_code: assert property (@(posedge clock) disable iff (!rst_n)
    pull_reg[9] == GSL_PULL_UP |-> pull_up_en[9] && !pull_down_en[9])
    else $error("pull-up code wrong");

  // ----------------------------------------
  // Bus, event and pin filter checks
  // ----------------------------------------
  // Read data is zero outside the answer cycle
  a_rdata_idle_zero: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && !rd_stb |=> rdata == 32'h0)
    else $error("read data not zero when idle");

  // Status read clears when no event arrives
  a_stat_read_clears: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && rd_stb && addr == `GSL_OFF_IRQ_STAT && pin_det == 32'h0 && !port_detect
      |=> stat_reg == 2'h0)
    else $error("status read did not clear");

  // Unmasked status keeps the interrupt up
  a_irq_follows_status: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && (stat_reg & mask_reg) != 2'h0 && !rd_stb && !wr_stb |=> irq)
    else $error("interrupt lost while status set");

  // Low enable freezes state
  a_freeze_holds_state: assert property (@(posedge clock) disable iff (!rst_n)
    !clk_en |=> hit_reg == $past(hit_reg) && dir_reg == $past(dir_reg)
      && lvl_reg == $past(lvl_reg))
    else $error("state moved while frozen");

  // Filtered level holds while stages disagree
  a_filter_needs_agree: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && sync2_reg[0] != sync3_reg[0] |=> lvl_reg[0] == $past(lvl_reg[0]))
    else $error("filter passed a disagreeing level");

endmodule // gsl_port

// ---- test/gsl_pin_env.sv ----
`timescale 1ns/10ps
module gsl_pin_env
(
  // Clock
  input  wire logic        clock,
  // Device side
  input  wire logic [31:0] pin_out,
  input  wire logic [31:0] pin_oe,
  input  wire logic [31:0] pull_up_en,
  input  wire logic [31:0] pull_down_en,
  // Outside drivers
  input  wire logic [31:0] ext_drv,
  input  wire logic [31:0] ext_val,
  // Resolved levels
  output logic [31:0]      pin_in
);
  logic [31:0] float_reg = 32'h0;

  // Undriven unpulled pins wander every cycle
  always_ff @(posedge clock)
  begin
    float_reg <= ~float_reg;
  end

  // Wire level: device drive, then outside drive, then pulls
  always_comb
  begin
    pin_in = (pin_oe & pin_out) | (~pin_oe & ((ext_drv & ext_val)
           | (~ext_drv & (pull_up_en | (~pull_down_en & float_reg)))));
  end
endmodule // gsl_pin_env

// ---- test/gsl_port_bench.sv ----
`timescale 1ns/10ps
module gsl_port_bench;
  import gsl_pkg::*;
  logic clock, rst_n, clk_en, wr_stb, rd_stb, port_detect, irq;
  gsl_addr_t addr;
  gsl_word_t wdata, rdata, rv;
  logic [31:0] pin_in, pin_out, pin_oe, pu, pd, ext_drv, ext_val;
  logic [15:0] rnd;
  int err_count, samples_checked, p, k;

  // ----------------------------------------
  // Clock, device, pins
  // ----------------------------------------
  initial
  begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  gsl_port dut (.clock(clock), .rst_n(rst_n), .clk_en(clk_en), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .pull_up_en(pu), .pull_down_en(pd), .port_detect(port_detect),
    .irq(irq));
  gsl_pin_env env (.clock(clock), .pin_out(pin_out), .pin_oe(pin_oe), .pull_up_en(pu),
    .pull_down_en(pd), .ext_drv(ext_drv), .ext_val(ext_val), .pin_in(pin_in));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return v[0] ? ((v >> 1) ^ 16'hb400) : (v >> 1);
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input gsl_addr_t a, input gsl_word_t d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge clock);
    wr_stb <= 1'b0;
  endtask
  task automatic rd(input gsl_addr_t a, output gsl_word_t d);
    @(posedge clock);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clock);
    rd_stb <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic wait_sig(input int which, input logic lvl);
    int n;
    n = 0;
    while (((which == 0) ? port_detect : irq) !== lvl && n < 20)
    begin
      @(posedge clock);
      #1 n++;
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Watchdog
  initial
  begin
    #80000;
    err_count++;
    summarize();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    err_count = 0;
    samples_checked = 0;
    rst_n = 1'b0;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    clk_en = 1'b1;
    addr = 12'h000;
    wdata = 32'h0;
    ext_drv = 32'hffff_ffff;
    ext_val = 32'h0;
    rnd = 16'd1125;
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    rd(12'h700, rv); chk("cfg0 reset", rv, 32'h2);
    rd(12'h524, rv); chk("detsel reset", rv, 32'h0);
    rd(12'h520, rv); chk("latch reset", rv, 32'h0);
    rd(12'hffc, rv); chk("unmapped", rv, 32'h0);
    // Sense high and low on random pins, both detect sources
    for (k = 0; k < 6; k++)
    begin
      rnd = lfsr(rnd);
      p = rnd[4:0];
      ext_val[p] <= k[0];
      repeat (8) @(posedge clock);
      wr(12'(12'h700 + 4 * p), (k[0] ? 32'h3 : 32'h2) << 16);
      repeat (8) @(posedge clock);
      rd(12'h520, rv); chk("latch idle", rv, 32'h0);
      ext_val[p] <= ~k[0];
      wait_sig(0, 1'b1);
      chk("live detect", port_detect, 1'b1);
      rd(12'h520, rv); chk("latch hit", rv, 32'h1 << p);
      chk("irq masked", irq, 1'b0);
      ext_val[p] <= k[0];
      repeat (8) @(posedge clock);
      #1 chk("live idle", port_detect, 1'b0);
      wr(12'h524, 32'h1);
      @(posedge clock);
      #1 chk("latched detect", port_detect, 1'b1);
      wr(12'h520, ~(32'h1 << p));
      rd(12'h520, rv); chk("write zero", rv, 32'h1 << p);
      wr(12'h520, 32'h1 << p);
      rd(12'h520, rv); chk("write one", rv, 32'h0);
      chk("latched idle", port_detect, 1'b0);
      wr(12'h524, 32'h0);
      wr(12'(12'h700 + 4 * p), 32'h2);
    end
    // Disabled sense and disconnected buffer never latch
    ext_val <= 32'hffff_ffff;
    wr(12'h704, 32'h0000_0000);
    wr(12'h708, 32'h0002_0002);
    repeat (10) @(posedge clock);
    rd(12'h520, rv); chk("no latch", rv, 32'h0);
    ext_val <= 32'h0;
    wr(12'h704, 32'h2);
    wr(12'h708, 32'h2);
    // Direction, pull codes and output level on pin 9
    wr(12'h504, 32'h200);
    for (k = 0; k < 4; k++)
    begin
      wr(12'h724, {30'h0, k[1:0]} << 2 | k[0]);
      rd(12'h724, rv); chk("cfg9 readback", rv, {30'h0, k[1:0]} << 2 | k[0]);
      chk("dir", pin_oe, {22'h0, k[0], 9'h0});
      chk("pull up", pu, (k == 3) ? 32'h200 : 32'h0);
      chk("pull down", pd, (k == 1) ? 32'h200 : 32'h0);
      chk("pin out", pin_out, 32'h200);
      rd(12'h518, rv); chk("dir shared", rv, {22'h0, k[0], 9'h0});
    end
    wr(12'h51c, 32'h200);
    rd(12'h724, rv); chk("dir clear shared", rv, 32'hc);
    wr(12'h724, 32'h2);
    // Frozen block ignores a write
    clk_en <= 1'b0;
    wr(12'h724, 32'h1);
    clk_en <= 1'b1;
    rd(12'h724, rv); chk("frozen write", rv, 32'h2);
    // Interrupt on a new latch bit, stale events cleared first
    rd(12'h540, rv); chk("stale status", rv, 32'h3);
    wr(12'h544, 32'h1);
    wr(12'h714, 32'h0002_0000);
    ext_val[5] <= 1'b1;
    wait_sig(1, 1'b1);
    chk("irq raised", irq, 1'b1);
    ext_val[5] <= 1'b0;
    wr(12'h714, 32'h2);
    rd(12'h540, rv); chk("irq status", rv[0], 1'b1);
    @(posedge clock);
    #1 chk("irq cleared", irq, 1'b0);
    summarize();
  end
endmodule // gsl_port_bench
